/* File: core/ext_bus_pkg.sv */
package ext_bus_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  localparam logic [23:0] OFS_PMC0 = 24'h00005E;
  localparam logic [23:0] OFS_PMC1 = 24'h00005F;
  localparam logic [23:0] OFS_OSC0 = 24'h00006C;
  localparam logic [23:0] INT_AREA_END = 24'h000880;

  localparam int BIT_EVAL = 0;
  localparam int BIT_NOWAIT = 2;
  localparam int BIT_WAIT_SEL = 0;
  localparam int BIT_SIG_DIS = 6;

  localparam logic RST_EVAL = 1'b0;
  localparam logic RST_NOWAIT = 1'b0;
  localparam logic RST_WAIT_SEL = 1'b0;
  localparam logic RST_SIG_DIS = 1'b0;

  // One bus tick is two periods of the internal CPU clock.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 20;
  localparam int TICK_DIV_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Whole access length in ticks, address phase included.
  localparam logic [2:0] TICKS_NOWAIT = 3'h2;
  localparam logic [2:0] TICKS_WAIT15 = 3'h3;
  localparam logic [2:0] TICKS_WAIT20 = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_STRB = 2'b11
  } bus_state_t;

endpackage : ext_bus_pkg

/* File: core/tick_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  output logic tick_out
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  if (DIV < 2) begin : g_bad_div
    $error("tick_divider needs DIV of at least 2");
  end

  logic [CW-1:0] cnt_r;

  assign tick_out = (cnt_r == LAST) & ~clear_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
    end else if (clear_in || cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule : tick_divider
`default_nettype wire

/* File: core/phase_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module phase_counter #(
  parameter int W = 3
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [W-1:0] load_val_in,
  input wire logic dec_in,
  output logic last_out
);

  if (W < 1) begin : g_bad_w
    $error("phase_counter needs W of at least 1");
  end

  logic [W-1:0] cnt_r;

  assign last_out = (cnt_r == W'(1));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
    end else if (load_in) begin
      cnt_r <= load_val_in;
    end else if (dec_in && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule : phase_counter

/* File: core/external_memory_bus_interface.sv */
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_interface #(
  parameter int TICK_DIV = ext_bus_pkg::TICK_DIV_DFLT
) (
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic BUS_WIDTH_STRAP_IN,
  input wire logic REQ_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic REQ_WORD_IN,
  input wire logic [ext_bus_pkg::ADDR_W-1:0] REQ_ADDR_IN,
  input wire logic [ext_bus_pkg::DATA_W-1:0] REQ_WDATA_IN,
  input wire logic [7:0] MID_IN,
  input wire logic [7:0] UP_IN,
  output var logic BUSY_OUT,
  output var logic DONE_OUT,
  output var logic [ext_bus_pkg::DATA_W-1:0] RDATA_OUT,
  output var logic EVAL_MODE_OUT,
  output var logic [7:0] ADDR_LO_OUT,
  output var logic [7:0] MID_OUT,
  output var logic MID_OE_OUT,
  output var logic [7:0] UP_OUT,
  output var logic UP_OE_OUT,
  output var logic E_N_OUT,
  output var logic RW_OUT,
  output var logic BYTE_HIGH_ENABLE_N_OUT,
  output var logic ALE_OUT
);
  import ext_bus_pkg::*;

  if (TICK_DIV < 2) begin : g_bad_div
    $error("TICK_DIV must be at least 2");
  end

  bus_state_t state_r, state_nxt;
  logic [23:0] addr_r;
  logic [15:0] wdata_r;
  logic write_r, word_r, int_r, narrow_r, second_r, second_nxt;
  logic [2:0] strb_ticks_r;
  logic eval_r, nowait_r, wait_sel_r, sig_dis_r;
  logic tick, last;

  // Request fields as seen this cycle: fresh on accept, held afterwards.
  wire accept = REQ_IN & (state_r == ST_IDLE);
  wire [23:0] a_addr = accept ? REQ_ADDR_IN : addr_r;
  wire [15:0] a_wdata = accept ? REQ_WDATA_IN : wdata_r;
  wire a_write = accept ? REQ_WRITE_IN : write_r;
  wire a_word = accept ? (REQ_WORD_IN & ~REQ_ADDR_IN[0]) : word_r;
  wire a_int = accept ? (REQ_ADDR_IN < INT_AREA_END) : int_r;
  // On-chip area always runs 16 bits wide whatever the strap says.
  wire a_narrow = accept ? (BUS_WIDTH_STRAP_IN & ~a_int) : narrow_r;

  wire finish = (state_r == ST_STRB) & tick & last;
  wire split = word_r & narrow_r;
  wire more = finish & split & ~second_r;

  // An 8-bit bus moves a word as even byte then odd byte.
  wire cur_a0 = (a_word & a_narrow) ? second_nxt : a_addr[0];
  wire both_lanes = a_word & ~a_narrow;
  wire odd_part = both_lanes | cur_a0;
  wire even_part = both_lanes | ~cur_a0;
  wire in_data = (state_nxt == ST_STRB);
  wire strobe_on = in_data & ~(a_int & sig_dis_r);

  // Wait settings are frozen at accept so a register write cannot
  // stretch an access already under way.
  wire [2:0] cfg_ticks = (a_int | nowait_r) ? TICKS_NOWAIT :
                         (wait_sel_r ? TICKS_WAIT15 : TICKS_WAIT20);
  wire [2:0] strb_load = cfg_ticks - 3'h1;

  wire ale_nxt = (state_nxt == ST_ADDR);
  wire rw_nxt = (state_nxt == ST_IDLE) | ~a_write;
  wire bhe_n_nxt = (state_nxt == ST_IDLE) | ~odd_part;
  wire [7:0] lo_nxt = {a_addr[7:1], cur_a0};
  wire mid_data = ~a_narrow & in_data;
  wire [7:0] mid_nxt = mid_data ? a_wdata[15:8] : a_addr[15:8];
  wire mid_oe_nxt = mid_data ? (a_write & odd_part) : 1'b1;
  wire [7:0] up_byte = (a_narrow & cur_a0) ? a_wdata[15:8] : a_wdata[7:0];
  wire [7:0] up_nxt = in_data ? up_byte : a_addr[23:16];
  wire up_oe_nxt = in_data ? (a_write & (a_narrow | even_part)) : 1'b1;

  // Mode register file, reached by on-chip accesses at its own addresses.
  wire hit_pmc = (addr_r[23:1] == OFS_PMC0[23:1]);
  wire hit_osc = (addr_r[23:1] == OFS_OSC0[23:1]);
  wire done_a0 = split ? second_r : addr_r[0];
  // A word split over the 8-bit bus fills one lane per pass only.
  wire whole_word = word_r & ~split;
  wire lane_even = whole_word | ~done_a0;
  wire lane_odd = whole_word | done_a0;
  wire reg_wr = finish & write_r & int_r;
  logic [7:0] pmc0_byte, pmc1_byte, osc0_byte;

  always_comb begin
    pmc0_byte = 8'h00;
    pmc0_byte[BIT_EVAL] = eval_r;
    pmc0_byte[BIT_NOWAIT] = nowait_r;
    pmc1_byte = 8'h00;
    pmc1_byte[BIT_WAIT_SEL] = wait_sel_r;
    osc0_byte = 8'h00;
    osc0_byte[BIT_SIG_DIS] = sig_dis_r;
  end

  wire [7:0] reg_even = hit_pmc ? pmc0_byte : (hit_osc ? osc0_byte : 8'h00);
  wire [7:0] reg_odd = hit_pmc ? pmc1_byte : 8'h00;
  // On-chip reads take register data; the pins are never looked at.
  wire [7:0] rd_even = int_r ? reg_even : UP_IN;
  wire [7:0] rd_odd = int_r ? reg_odd : (narrow_r ? UP_IN : MID_IN);
  wire cap = finish & ~write_r;
  wire [15:0] rdata_nxt = {
    (cap & lane_odd) ? rd_odd : RDATA_OUT[15:8],
    (cap & lane_even) ? rd_even : RDATA_OUT[7:0]};

  tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .clear_in(accept),
    .tick_out(tick)
  );

  phase_counter #(
    .W(3)
  ) u_phase (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .load_in((state_r == ST_ADDR) & tick),
    .load_val_in(strb_ticks_r),
    .dec_in((state_r == ST_STRB) & tick),
    .last_out(last)
  );

  always_comb begin
    second_nxt = second_r;
    if (accept) begin
      second_nxt = 1'b0;
    end else if (more) begin
      second_nxt = 1'b1;
    end
  end

  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = accept ? ST_ADDR : ST_IDLE;
      ST_ADDR: state_nxt = tick ? ST_STRB : ST_ADDR;
      ST_STRB: state_nxt = finish ? (more ? ST_ADDR : ST_IDLE) : ST_STRB;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_r <= ST_IDLE;
      second_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      second_r <= second_nxt;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      addr_r <= 24'h000000;
      wdata_r <= 16'h0000;
      write_r <= 1'b0;
      word_r <= 1'b0;
      int_r <= 1'b0;
      narrow_r <= 1'b0;
      strb_ticks_r <= 3'h1;
    end else if (accept) begin
      addr_r <= a_addr;
      wdata_r <= a_wdata;
      write_r <= a_write;
      word_r <= a_word;
      int_r <= a_int;
      narrow_r <= a_narrow;
      strb_ticks_r <= strb_load;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      eval_r <= RST_EVAL;
      nowait_r <= RST_NOWAIT;
      wait_sel_r <= RST_WAIT_SEL;
      sig_dis_r <= RST_SIG_DIS;
    end else if (reg_wr) begin
      if (hit_pmc && lane_even) begin
        eval_r <= wdata_r[BIT_EVAL];
        nowait_r <= wdata_r[BIT_NOWAIT];
      end
      if (hit_pmc && lane_odd) begin
        wait_sel_r <= wdata_r[8 + BIT_WAIT_SEL];
      end
      if (hit_osc && lane_even) begin
        sig_dis_r <= wdata_r[BIT_SIG_DIS];
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ALE_OUT <= 1'b0;
      E_N_OUT <= 1'b1;
      RW_OUT <= 1'b1;
      BYTE_HIGH_ENABLE_N_OUT <= 1'b1;
      ADDR_LO_OUT <= 8'h00;
      MID_OUT <= 8'h00;
      MID_OE_OUT <= 1'b1;
      UP_OUT <= 8'h00;
      UP_OE_OUT <= 1'b1;
    end else begin
      ALE_OUT <= ale_nxt;
      E_N_OUT <= ~strobe_on;
      RW_OUT <= rw_nxt;
      BYTE_HIGH_ENABLE_N_OUT <= bhe_n_nxt;
      ADDR_LO_OUT <= lo_nxt;
      MID_OUT <= mid_nxt;
      MID_OE_OUT <= mid_oe_nxt;
      UP_OUT <= up_nxt;
      UP_OE_OUT <= up_oe_nxt;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      RDATA_OUT <= 16'h0000;
      EVAL_MODE_OUT <= RST_EVAL;
    end else begin
      BUSY_OUT <= (state_nxt != ST_IDLE);
      DONE_OUT <= finish & ~more;
      RDATA_OUT <= rdata_nxt;
      EVAL_MODE_OUT <= eval_r;
    end
  end

  property p_ale_pulse;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      $rose(ALE_OUT) |-> ALE_OUT[*2] ##1 !ALE_OUT;
  endproperty
  a_ale_pulse: assert property (p_ale_pulse)
    else $error("address latch enable high for wrong length");

  property p_strobe_follows_ale;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      $fell(ALE_OUT) && !(int_r && sig_dis_r) |-> !E_N_OUT && ALE_OUT == 1'b0;
  endproperty
  a_strobe_follows_ale: assert property (p_strobe_follows_ale)
    else $error("strobe not asserted after address phase");

  property p_internal_nowait;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      $fell(E_N_OUT) && int_r |-> !E_N_OUT[*2] ##1 E_N_OUT;
  endproperty
  a_internal_nowait: assert property (p_internal_nowait)
    else $error("on-chip access was lengthened");

  property p_wait_double;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      $fell(E_N_OUT) && strb_ticks_r == 3'h3 |-> !E_N_OUT[*6] ##1 E_N_OUT;
  endproperty
  a_wait_double: assert property (p_wait_double)
    else $error("double-length strobe has wrong width");

  property p_wait_config;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      accept && !a_int && !nowait_r |=>
        strb_ticks_r == ($past(wait_sel_r) ? 3'h2 : 3'h3);
  endproperty
  a_wait_config: assert property (p_wait_config)
    else $error("wait length does not follow the select bit");

  property p_sig_disable;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      state_r != ST_IDLE && int_r && sig_dis_r |-> E_N_OUT;
  endproperty
  a_sig_disable: assert property (p_sig_disable)
    else $error("strobe pulsed on on-chip access while disabled");

  property p_odd_byte_enable;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      !ALE_OUT && BUSY_OUT && ADDR_LO_OUT[0] |-> !BYTE_HIGH_ENABLE_N_OUT;
  endproperty
  a_odd_byte_enable: assert property (p_odd_byte_enable)
    else $error("odd byte access without byte-high-enable");

  property p_read_release;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      !E_N_OUT && RW_OUT |-> !UP_OE_OUT && !(MID_OE_OUT && !narrow_r);
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("data lanes driven during a read strobe");

  property p_narrow_mid_addr;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      BUSY_OUT && narrow_r |-> MID_OE_OUT && MID_OUT == addr_r[15:8];
  endproperty
  a_narrow_mid_addr: assert property (p_narrow_mid_addr)
    else $error("middle group left address duty on 8-bit bus");

  property p_addr_phase;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      ALE_OUT |-> UP_OUT == addr_r[23:16] && MID_OUT == addr_r[15:8]
        && ADDR_LO_OUT[7:1] == addr_r[7:1];
  endproperty
  a_addr_phase: assert property (p_addr_phase)
    else $error("address phase shows wrong address");

endmodule : external_memory_bus_interface
`default_nettype wire

/* File: verification/ext_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic clk_in,
  input wire logic strap_in,
  input wire logic e_n_in,
  input wire logic rw_in,
  input wire logic bhe_n_in,
  input wire logic ale_in,
  input wire logic [7:0] addr_lo_in,
  input wire logic [7:0] mid_pin_in,
  input wire logic [7:0] up_pin_in,
  input wire logic mid_oe_in,
  input wire logic up_oe_in,
  output logic [7:0] mid_drv_out,
  output logic [7:0] up_drv_out
);
  logic [7:0] mem_r [0:255];
  logic [23:0] lat_r;
  logic [7:0] mid_last_r = 8'h00;
  logic [7:0] up_last_r = 8'h00;
  wire logic [7:0] even_a = {lat_r[7:1], 1'h0};
  wire logic [7:0] odd_a = {lat_r[7:1], 1'h1};
  wire logic rd_phase = !e_n_in && rw_in;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_r[i] = 8'(i) ^ 8'hA5;
    end
  end

  always_latch begin
    if (ale_in) lat_r = {up_pin_in, mid_pin_in, addr_lo_in};
  end

  // Released lanes toggle so a stale value can never pass for real data.
  always_comb begin
    mid_drv_out = ~mid_last_r;
    up_drv_out = ~up_last_r;
    if (rd_phase && strap_in) begin
      up_drv_out = mem_r[lat_r[7:0]];
    end else if (rd_phase) begin
      if (!lat_r[0]) up_drv_out = mem_r[even_a];
      if (!bhe_n_in) mid_drv_out = mem_r[odd_a];
    end
  end

  always @(posedge clk_in) begin
    mid_last_r <= mid_drv_out;
    up_last_r <= up_drv_out;
    if (!e_n_in && !rw_in && strap_in && up_oe_in) begin
      mem_r[lat_r[7:0]] <= up_pin_in;
    end else if (!e_n_in && !rw_in) begin
      if (!lat_r[0] && up_oe_in) mem_r[even_a] <= up_pin_in;
      if (!bhe_n_in && mid_oe_in) mem_r[odd_a] <= mid_pin_in;
    end
  end
endmodule : ext_mem_model
`default_nettype wire

/* File: verification/tb_external_memory_bus_interface.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); \
  end \
end
module tb_external_memory_bus_interface;
  import ext_bus_pkg::*;
  localparam int D = 2;
  logic MCLK_IN = 1'h0;
  logic RESET_N_IN = 1'h0;
  logic BUS_WIDTH_STRAP_IN = 1'h0;
  logic REQ_IN = 1'h0;
  logic REQ_WRITE_IN = 1'h0;
  logic REQ_WORD_IN = 1'h0;
  logic [ADDR_W-1:0] REQ_ADDR_IN = 24'h000000;
  logic [DATA_W-1:0] REQ_WDATA_IN = 16'h0000;
  logic BUSY_OUT, DONE_OUT, EVAL_MODE_OUT, MID_OE_OUT, UP_OE_OUT;
  logic E_N_OUT, RW_OUT, BYTE_HIGH_ENABLE_N_OUT, ALE_OUT;
  logic [DATA_W-1:0] RDATA_OUT;
  logic [7:0] ADDR_LO_OUT, MID_OUT, UP_OUT;
  wire logic [7:0] mid_far, up_far;
  wire logic [7:0] mid_w = MID_OE_OUT ? MID_OUT : mid_far;
  wire logic [7:0] up_w = UP_OE_OUT ? UP_OUT : up_far;
  int mismatches = 0;
  int checks_done = 0;
  int len, en_lo, ale_hi, bhe_lo, a0_hi, rw_lo, moe_lo, busy_hi;
  logic [15:0] rd;

  external_memory_bus_interface #(.TICK_DIV(D)) dut (
    .MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN),
    .BUS_WIDTH_STRAP_IN(BUS_WIDTH_STRAP_IN), .REQ_IN(REQ_IN),
    .REQ_WRITE_IN(REQ_WRITE_IN), .REQ_WORD_IN(REQ_WORD_IN),
    .REQ_ADDR_IN(REQ_ADDR_IN), .REQ_WDATA_IN(REQ_WDATA_IN),
    .MID_IN(mid_w), .UP_IN(up_w), .BUSY_OUT(BUSY_OUT),
    .DONE_OUT(DONE_OUT), .RDATA_OUT(RDATA_OUT),
    .EVAL_MODE_OUT(EVAL_MODE_OUT), .ADDR_LO_OUT(ADDR_LO_OUT),
    .MID_OUT(MID_OUT), .MID_OE_OUT(MID_OE_OUT), .UP_OUT(UP_OUT),
    .UP_OE_OUT(UP_OE_OUT), .E_N_OUT(E_N_OUT), .RW_OUT(RW_OUT),
    .BYTE_HIGH_ENABLE_N_OUT(BYTE_HIGH_ENABLE_N_OUT), .ALE_OUT(ALE_OUT));

  ext_mem_model far (
    .clk_in(MCLK_IN), .strap_in(BUS_WIDTH_STRAP_IN), .e_n_in(E_N_OUT),
    .rw_in(RW_OUT), .bhe_n_in(BYTE_HIGH_ENABLE_N_OUT), .ale_in(ALE_OUT),
    .addr_lo_in(ADDR_LO_OUT), .mid_pin_in(mid_w), .up_pin_in(up_w),
    .mid_oe_in(MID_OE_OUT), .up_oe_in(UP_OE_OUT),
    .mid_drv_out(mid_far), .up_drv_out(up_far));

  always #5 MCLK_IN = ~MCLK_IN;

  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  // Pin statistics cover the len cycles after the accepting edge.
  task automatic access(input logic wr, input logic wd,
                        input logic [23:0] a, input logic [15:0] d);
    @(negedge MCLK_IN);
    REQ_IN = 1'h1;
    REQ_WRITE_IN = wr;
    REQ_WORD_IN = wd;
    REQ_ADDR_IN = a;
    REQ_WDATA_IN = d;
    en_lo = 0;
    ale_hi = 0;
    bhe_lo = 0;
    a0_hi = 0;
    rw_lo = 0;
    moe_lo = 0;
    busy_hi = 0;
    @(negedge MCLK_IN);
    REQ_IN = 1'h0;
    len = 0;
    while (DONE_OUT !== 1'h1 && len < 40) begin
      busy_hi += int'(BUSY_OUT === 1'h1);
      en_lo += int'(E_N_OUT === 1'h0);
      ale_hi += int'(ALE_OUT === 1'h1);
      bhe_lo += int'(BYTE_HIGH_ENABLE_N_OUT === 1'h0);
      a0_hi += int'(ALE_OUT === 1'h1 && ADDR_LO_OUT[0] === 1'h1);
      rw_lo += int'(E_N_OUT === 1'h0 && RW_OUT === 1'h0);
      moe_lo += int'(MID_OE_OUT === 1'h0);
      @(negedge MCLK_IN);
      len++;
    end
    if (DONE_OUT !== 1'h1) mismatches++;
    rd = RDATA_OUT;
  endtask : access

  task automatic wreg(input logic [23:0] a, input logic [7:0] b);
    access(1'h1, 1'h0, a, a[0] ? {b, 8'h00} : {8'h00, b});
  endtask : wreg

  // Sixteen short accesses need about 1.2 us; the limit leaves wide margin.
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (4) @(negedge MCLK_IN);
    RESET_N_IN = 1'h1;
    `CHK("idle strobe", 1'h1, E_N_OUT)
    `CHK("idle latch enable", 1'h0, ALE_OUT)
    access(1'h0, 1'h1, OFS_PMC0, 16'h0000);
    `CHK("mode regs after reset", 16'h0000, rd)
    `CHK("on-chip length", D * 2, len)
    `CHK("on-chip busy span", D * 2, busy_hi)
    access(1'h1, 1'h1, 24'h100010, 16'hBEEF);
    `CHK("double length", D * 4, len)
    `CHK("double strobe", 6, en_lo)
    `CHK("write direction", 6, rw_lo)
    `CHK("latch enable width", D, ale_hi)
    `CHK("word odd lane", 1'h1, bhe_lo > 0)
    access(1'h0, 1'h1, 24'h100010, 16'h0000);
    `CHK("wide word read", 16'hBEEF, rd)
    `CHK("read direction", 0, rw_lo)
    access(1'h0, 1'h1, 24'h000100, 16'h0000);
    `CHK("on-chip ignores pins", 16'h0000, rd)
    `CHK("on-chip strobe", 2, en_lo)
    wreg(OFS_PMC1, 8'h01);
    access(1'h0, 1'h1, 24'h100010, 16'h0000);
    `CHK("one and a half length", D * 3, len)
    `CHK("one and a half strobe", 4, en_lo)
    wreg(OFS_PMC0, 8'h04);
    access(1'h1, 1'h0, 24'h100013, 16'h5A00);
    `CHK("no wait length", D * 2, len)
    `CHK("odd byte address bit", D, a0_hi)
    `CHK("odd byte enable", 1'h1, bhe_lo > 0)
    access(1'h0, 1'h0, 24'h100012, 16'h0000);
    `CHK("even byte enable", 0, bhe_lo)
    access(1'h0, 1'h1, 24'h100012, 16'h0000);
    `CHK("odd lane only", 16'h5AB7, rd)
    BUS_WIDTH_STRAP_IN = 1'h1;
    access(1'h1, 1'h1, 24'h100020, 16'h1234);
    `CHK("narrow two passes", D * 4, len)
    `CHK("middle group address", 0, moe_lo)
    access(1'h0, 1'h1, 24'h100020, 16'h0000);
    `CHK("narrow word read", 16'h1234, rd)
    access(1'h0, 1'h1, OFS_PMC0, 16'h0000);
    `CHK("internal width", 16'h0104, rd)
    `CHK("internal one pass", D * 2, len)
    wreg(OFS_OSC0, 8'h40);
    access(1'h0, 1'h1, OFS_PMC0, 16'h0000);
    `CHK("strobe held off", 0, en_lo)
    wreg(OFS_PMC0, 8'h05);
    repeat (2) @(negedge MCLK_IN);
    `CHK("evaluation mode", 1'h1, EVAL_MODE_OUT)
    complete_run();
  end
endmodule : tb_external_memory_bus_interface
`default_nettype wire
